// file: pld_checker_props.sv
/*
  Port-level checker for the dual-channel phase lock detector.
  Assumes one clock, core_clk, and the asynchronous active-low rst_n.
*/
`timescale 1ns/100ps
module pld_checker_props (
  input wire logic                                       core_clk,
  input wire logic                                       rst_n,
  input wire pld_pkg::pld_axi_req_type                   axiReq,
  input wire pld_pkg::pld_axi_resp_type                  axiResp,
  input wire pld_pkg::pld_chan_in_type  [pld_pkg::NUM_CH-1:0] chanIn,
  input wire pld_pkg::pld_chan_out_type [pld_pkg::NUM_CH-1:0] chanOut
);
  import pld_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence wrTaken;
    axiReq.awvalid && axiResp.awready && axiReq.wvalid && axiResp.wready;
  endsequence
  sequence rdTaken;
    axiReq.arvalid && axiResp.arready;
  endsequence
  chk_write_answer: assert property (wrTaken |-> ##2 axiResp.bvalid)
    else $error("write response not given two cycles after handshake");
  chk_bresp_hold: assert property (axiResp.bvalid && !axiReq.bready |=>
    axiResp.bvalid && $stable(axiResp.bresp)) else $error("write response dropped");
  chk_read_answer: assert property (rdTaken |=> axiResp.rvalid)
    else $error("read data not valid one cycle after address");
  chk_rdata_hold: assert property (axiResp.rvalid && !axiReq.rready |=>
    axiResp.rvalid && $stable(axiResp.rdata)) else $error("read data changed early");
  chk_ar_blocked: assert property (axiResp.rvalid |-> !axiResp.arready)
    else $error("second read accepted while one is open");
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    // Quiet for three cycles so a registered update from earlier has landed
    sequence quiet;
      (!chanIn[c].sampleValid && !chanIn[c].freerun && !chanIn[c].holdover) [*3];
    endsequence
    chk_forced_unlock: assert property ((chanIn[c].freerun || chanIn[c].holdover) |=>
      !chanOut[c].phaseLocked) else $error("lock shown in freerun or holdover");
    chk_lock_hold: assert property (quiet |=> $stable(chanOut[c].phaseLocked))
      else $error("lock state changed without a sample");
    // After a cycle without freerun or holdover, unlocked means level at most the high mark
    chk_slew_no_lock: assert property (chanIn[c].sampleValid && chanIn[c].slewLimiting &&
      !chanOut[c].phaseLocked && !$past(chanIn[c].freerun) && !$past(chanIn[c].holdover)
      |=> !chanOut[c].phaseLocked) else $error("slew sample locked");
  end
endmodule

bind pld_phase_lock_detector pld_checker_props i_props (.core_clk, .rst_n, .axiReq, .axiResp,
  .chanIn, .chanOut);

// file: pld_phase_lock_detector.sv
/*
  Dual-channel phase lock detector with lock events and the NCO tuning word
  smoothing filter, behind an AXI4-Lite register slave.
  Assumes phase error samples, slew limiter, freerun, holdover and tuning
  words come from logic on core_clk, so none of them is synchronised here.
*/
`timescale 1ns/100ps
module pld_phase_lock_detector (
  input  logic                                      core_clk,
  input  logic                                      rst_n,
  input  pld_pkg::pld_axi_req_type                  axiReq,
  output pld_pkg::pld_axi_resp_type                 axiResp,
  input  pld_pkg::pld_chan_in_type  [pld_pkg::NUM_CH-1:0] chanIn,
  output pld_pkg::pld_chan_out_type [pld_pkg::NUM_CH-1:0] chanOut
);
  import pld_pkg::*;

  pld_state_type state_reg;
  pld_state_type state_next;

  // Saturating tub update; one step per sample, fill or drain only
  function automatic logic signed [11:0] tubStep(
    input logic signed [11:0] level,
    input logic               doFill,
    input logic [7:0]         fillStep,
    input logic [7:0]         drainStep
  );
    logic signed [12:0] sum;
    sum = doFill ? ({level[11], level} + $signed({5'h00, fillStep}))
                 : ({level[11], level} - $signed({5'h00, drainStep}));
    if (sum > TUB_FULL) begin
      sum = TUB_FULL;
    end else if (sum < TUB_EMPTY) begin
      sum = TUB_EMPTY;
    end
    return sum[11:0];
  endfunction

  // Magnitude of a signed phase error, sign ignored
  function automatic logic [24:0] errMag(input logic signed [24:0] err);
    errMag = err[24] ? 25'(-err) : 25'(err);
  endfunction

  // Read mux for one channel; returns hit flag in bit 32
  function automatic logic [32:0] chanRead(
    input pld_chan_state_type cs,
    input int                 c,
    input logic [13:0]        idx
  );
    logic [32:0] r;
    r = 33'h000000000;
    if (idx == IDX_FILTER_BW[c]) begin
      r = {1'b1, 28'h0000000, cs.filterBw};
    end else if (idx == IDX_EVENT_CLR[c]) begin
      r = {1'b1, 32'h00000000};
    end else if (idx == IDX_EVENT_LAT[c]) begin
      r = {1'b1, 30'h00000000, cs.events};
    end else if (idx == IDX_LIVE_STAT[c]) begin
      r = {1'b1, 30'h00000000, cs.locked, 1'b0};
    end else if (idx == IDX_TUB_LO[c]) begin
      r = {1'b1, 24'h000000, cs.tubLevel[7:0]};
    end else if (idx == IDX_TUB_HI[c]) begin
      r = {1'b1, 24'h000000, {4{cs.tubLevel[11]}}, cs.tubLevel[11:8]};
    end else if (idx == IDX_PROFILE[c] + PROF_THR_B0) begin
      r = {1'b1, 24'h000000, cs.threshold[7:0]};
    end else if (idx == IDX_PROFILE[c] + PROF_THR_B1) begin
      r = {1'b1, 24'h000000, cs.threshold[15:8]};
    end else if (idx == IDX_PROFILE[c] + PROF_THR_B2) begin
      r = {1'b1, 24'h000000, cs.threshold[23:16]};
    end else if (idx == IDX_PROFILE[c] + PROF_FILL) begin
      r = {1'b1, 24'h000000, cs.fillStep};
    end else if (idx == IDX_PROFILE[c] + PROF_DRAIN) begin
      r = {1'b1, 24'h000000, cs.drainStep};
    end
    return r;
  endfunction

  // Whether an index belongs to any mapped register of a channel
  function automatic logic isMapped(input pld_chan_state_type cs, input int c,
                                    input logic [13:0] idx);
    logic [32:0] r;
    r = chanRead(cs, c, idx);
    return r[32];
  endfunction

  always_comb begin
    logic [13:0]        wrIdx;
    logic [13:0]        rdIdx;
    logic               doWrite;
    logic               wrHit;
    logic [32:0]        rdWord;
    logic [32:0]        rdOne;
    logic [7:0]         wByte;
    logic               fillReq;
    logic               newLocked;
    logic [1:0]         evSet;
    logic [1:0]         evClr;
    logic signed [11:0] lvl;
    logic signed [48+FILT_FRACTIONAL_DIVIDE_PART:0] target;
    logic signed [48+FILT_FRACTIONAL_DIVIDE_PART:0] diff;
    logic signed [48:0] corrected;

    state_next = state_reg;
    wrIdx      = state_reg.awAddr[15:2];
    rdIdx      = axiReq.araddr[15:2];
    doWrite    = 1'b0;
    wrHit      = 1'b0;
    rdWord     = 33'h000000000;
    rdOne      = 33'h000000000;
    wByte      = state_reg.wData[7:0];
    fillReq    = 1'b0;
    newLocked  = 1'b0;
    evSet      = 2'b00;
    evClr      = 2'b00;
    lvl        = 12'sh000;
    target     = '0;
    diff       = '0;
    corrected  = '0;

    // Write address and data are taken independently, in either order
    if (axiReq.awvalid && state_reg.axi.awready) begin
      state_next.awHeld = 1'b1;
      state_next.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && state_reg.axi.wready) begin
      state_next.wHeld  = 1'b1;
      state_next.wData  = axiReq.wdata;
      state_next.wLane0 = axiReq.wstrb[0];
    end
    if (state_reg.axi.bvalid && axiReq.bready) begin
      state_next.axi.bvalid = 1'b0;
    end
    if (state_reg.awHeld && state_reg.wHeld && !state_reg.axi.bvalid) begin
      doWrite               = state_reg.wLane0;
      state_next.awHeld     = 1'b0;
      state_next.wHeld      = 1'b0;
      state_next.axi.bvalid = 1'b1;
      for (int c = 0; c < NUM_CH; c++) begin
        wrHit = wrHit | isMapped(state_reg.ch[c], c, wrIdx);
      end
      state_next.axi.bresp = wrHit ? RESP_OKAY : RESP_SLVERR;
    end
    state_next.axi.awready = !state_next.awHeld;
    state_next.axi.wready  = !state_next.wHeld;

    // Read: one outstanding; data registered with the response
    if (state_reg.axi.rvalid && axiReq.rready) begin
      state_next.axi.rvalid = 1'b0;
    end
    if (axiReq.arvalid && state_reg.axi.arready) begin
      for (int c = 0; c < NUM_CH; c++) begin
        rdOne  = chanRead(state_reg.ch[c], c, rdIdx);
        rdWord = rdWord | rdOne;
      end
      state_next.axi.rvalid = 1'b1;
      state_next.axi.rdata  = rdWord[31:0];
      state_next.axi.rresp  = rdWord[32] ? RESP_OKAY : RESP_SLVERR;
    end
    state_next.axi.arready = !state_next.axi.rvalid;

    for (int c = 0; c < NUM_CH; c++) begin
      // Register writes; only byte lane 0 carries data
      evClr = 2'b00;
      if (doWrite) begin
        if (wrIdx == IDX_FILTER_BW[c]) begin
          state_next.ch[c].filterBw = wByte[3:0];
        end
        if (wrIdx == IDX_EVENT_CLR[c]) begin
          evClr = wByte[EVT_UNLOCKED_BIT:EVT_LOCKED_BIT];
        end
        if (wrIdx == IDX_PROFILE[c] + PROF_THR_B0) begin
          state_next.ch[c].threshold[7:0] = wByte;
        end
        if (wrIdx == IDX_PROFILE[c] + PROF_THR_B1) begin
          state_next.ch[c].threshold[15:8] = wByte;
        end
        if (wrIdx == IDX_PROFILE[c] + PROF_THR_B2) begin
          state_next.ch[c].threshold[23:16] = wByte;
        end
        if (wrIdx == IDX_PROFILE[c] + PROF_FILL) begin
          state_next.ch[c].fillStep = wByte;
        end
        if (wrIdx == IDX_PROFILE[c] + PROF_DRAIN) begin
          state_next.ch[c].drainStep = wByte;
        end
      end

      // Tub: channels share nothing but the register bus
      lvl = state_reg.ch[c].tubLevel;
      if (chanIn[c].sampleValid) begin
        fillReq = (errMag(chanIn[c].phaseErr) <= {1'b0, state_reg.ch[c].threshold})
                  && !chanIn[c].slewLimiting;
        lvl = tubStep(lvl, fillReq, state_reg.ch[c].fillStep,
                      state_reg.ch[c].drainStep);
      end
      state_next.ch[c].tubLevel = lvl;

      // Hysteresis between the marks holds the previous state
      newLocked = state_reg.ch[c].locked;
      if (chanIn[c].freerun || chanIn[c].holdover) begin
        newLocked = 1'b0;
      end else if ($signed({lvl[11], lvl}) > TUB_HIGH_MARK) begin
        newLocked = 1'b1;
      end else if ($signed({lvl[11], lvl}) < TUB_LOW_MARK) begin
        newLocked = 1'b0;
      end
      state_next.ch[c].locked = newLocked;

      // A transition in the same cycle as its clear still latches
      evSet[EVT_LOCKED_BIT]   = newLocked && !state_reg.ch[c].locked;
      evSet[EVT_UNLOCKED_BIT] = !newLocked && state_reg.ch[c].locked;
      state_next.ch[c].events = (state_reg.ch[c].events & ~evClr) | evSet;

      // Single-pole smoother; shift per code halves the bandwidth.
      // The fractional guard bits keep small steps from stalling short of target.
      target = $signed({1'b0, chanIn[c].frequencyWord, {FILT_FRACTIONAL_DIVIDE_PART{1'b0}}});
      diff   = target - state_reg.ch[c].filtAcc;
      state_next.ch[c].filtAcc = state_reg.ch[c].filtAcc
                                 + (diff >>> (FILT_SHIFT_BASE
                                 + int'(state_reg.ch[c].filterBw)));
      corrected = $signed({1'b0, state_next.ch[c].filtAcc[48+FILT_FRACTIONAL_DIVIDE_PART-1:FILT_FRACTIONAL_DIVIDE_PART]});
      if (chanIn[c].compActive) begin
        corrected = corrected + 49'(chanIn[c].compCorr);
      end
      state_next.ch[c].ncoWord = corrected[47:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        state_reg.ch[c].tubLevel  <= TUB_RESET;
        state_reg.ch[c].threshold <= THR_RESET;
        state_reg.ch[c].fillStep  <= FILL_RESET;
        state_reg.ch[c].drainStep <= DRAIN_RESET;
        state_reg.ch[c].filterBw  <= BW_RESET;
      end
      state_reg.axi.awready <= 1'b1;
      state_reg.axi.wready  <= 1'b1;
      state_reg.axi.arready <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign axiResp = state_reg.axi;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      chanOut[c].phaseLocked = state_reg.ch[c].locked;
      chanOut[c].ncoWord     = state_reg.ch[c].ncoWord;
    end
  end

endmodule

// file: pld_pkg.sv
/*
  Package for the dual-channel phase lock detector and tuning word smoother:
  register indices, reset values, timing constants and the carrier structs.
  Assumes a single 40 MHz system clock and an AXI4-Lite master with 16-bit
  byte addresses; every register index maps to byte address index * 4.
*/
// Contract
// - Each of two channels has its own independent digital phase lock detector.
// - Tuning words pass a single-pole low-pass smoothing filter with variable gain.
// - Four-bit bandwidth code per channel; code 0 widest, each step halves it.
// - A new tuning word is approached gradually at the selected filter rate.
// - With clock compensation active the NCO word is corrected internally.
// - Status bit 1 shows live phase lock, 1 locked, 0 unlocked.
// - Event bit 0 latches lock gain, bit 1 latches lock loss, until cleared.
// - Writing clear bits 0 and 1 drops the matching latched events.
// - Signed tub level from -2048 to +2047, saturating, never wrapping.
// - Eight-bit fill step at profile offset 3, drain step at offset 4.
// - Unlock below -1025, lock above 1024, otherwise hold previous state.
// - Tub level readable as 12-bit signed over two consecutive registers.
// - Each phase error sample causes exactly one fill or one drain.
// - Phase threshold is 24-bit unsigned picoseconds at profile offsets 0 to 2.
// - Magnitude at or below threshold fills; otherwise one drain step.
// - While the slew limiter limits, fills are suppressed, drains allowed.
// - Zero fill or drain steps are accepted to force a fixed state.
// - Freerun or holdover forces the detector to report unlocked.
package pld_pkg;

  localparam int NUM_CH = 2;

  // Register indices; byte address is index * 4
  localparam logic [13:0] IDX_FILTER_BW [NUM_CH]  = '{14'h1009, 14'h1409};
  localparam logic [13:0] IDX_EVENT_CLR [NUM_CH]  = '{14'h200b, 14'h2010};
  localparam logic [13:0] IDX_EVENT_LAT [NUM_CH]  = '{14'h3010, 14'h3015};
  localparam logic [13:0] IDX_LIVE_STAT [NUM_CH]  = '{14'h3100, 14'h3200};
  localparam logic [13:0] IDX_TUB_LO    [NUM_CH]  = '{14'h3109, 14'h3209};
  localparam logic [13:0] IDX_TUB_HI    [NUM_CH]  = '{14'h310a, 14'h320a};
  localparam logic [13:0] IDX_PROFILE   [NUM_CH]  = '{14'h0800, 14'h0810};

  // Source profile byte offsets
  localparam logic [13:0] PROF_THR_B0 = 14'h0000;
  localparam logic [13:0] PROF_THR_B1 = 14'h0001;
  localparam logic [13:0] PROF_THR_B2 = 14'h0002;
  localparam logic [13:0] PROF_FILL   = 14'h0003;
  localparam logic [13:0] PROF_DRAIN  = 14'h0004;

  // Bit positions
  localparam int STAT_PHASE_LOCK_BIT = 1;
  localparam int EVT_LOCKED_BIT      = 0;
  localparam int EVT_UNLOCKED_BIT    = 1;

  // Tub limits and marks
  localparam logic signed [12:0] TUB_EMPTY     = -13'sd2048;
  localparam logic signed [12:0] TUB_FULL      = 13'sd2047;
  localparam logic signed [12:0] TUB_LOW_MARK  = -13'sd1025;
  localparam logic signed [12:0] TUB_HIGH_MARK = 13'sd1024;
  localparam logic [11:0]        TUB_RESET     = 12'h800;

  // Profile reset values
  localparam logic [23:0] THR_RESET   = 24'h0003e8;
  localparam logic [7:0]  FILL_RESET  = 8'h01;
  localparam logic [7:0]  DRAIN_RESET = 8'h01;
  localparam logic [3:0]  BW_RESET    = 4'h0;

  // Smoothing filter: code 0 is about 248 kHz at the system clock rate
  localparam int          SYS_CLK_HZ      = 40000000;
  localparam int          WIDEST_BW_HZ    = 248000;
  localparam int          FILT_SHIFT_BASE = $clog2(SYS_CLK_HZ / (6 * WIDEST_BW_HZ));
  localparam int          FILT_FRACTIONAL_DIVIDE_PART       = 8;

  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic        awvalid;
    logic [15:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [15:0] araddr;
    logic        rready;
  } pld_axi_req_type;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pld_axi_resp_type;

  typedef struct packed {
    logic               sampleValid;
    logic signed [24:0] phaseErr;
    logic               slewLimiting;
    logic               freerun;
    logic               holdover;
    logic [47:0]        frequencyWord;
    logic               compActive;
    logic signed [23:0] compCorr;
  } pld_chan_in_type;

  typedef struct packed {
    logic        phaseLocked;
    logic [47:0] ncoWord;
  } pld_chan_out_type;

  typedef struct packed {
    logic signed [11:0]           tubLevel;
    logic                         locked;
    logic [1:0]                   events;
    logic [23:0]                  threshold;
    logic [7:0]                   fillStep;
    logic [7:0]                   drainStep;
    logic [3:0]                   filterBw;
    logic signed [48+FILT_FRACTIONAL_DIVIDE_PART:0] filtAcc;
    logic [47:0]                  ncoWord;
  } pld_chan_state_type;

  typedef struct packed {
    pld_chan_state_type [NUM_CH-1:0] ch;
    logic                            awHeld;
    logic [15:0]                     awAddr;
    logic                            wHeld;
    logic [31:0]                     wData;
    logic                            wLane0;
    pld_axi_resp_type                axi;
  } pld_state_type;

endpackage

// file: testbench.sv
/*
  Self-checking bench: AXI4-Lite register tasks, sample tasks, directed tests.
  Assumes the design package, design and checker are compiled before it.
*/
`timescale 1ns/100ps
module testbench;
  import pld_pkg::*;
  localparam logic [47:0] NCO_T = 48'h1000_0000_0000;
  logic                          core_clk;
  logic                          rst_n;
  pld_axi_req_type               req;
  pld_axi_resp_type              resp;
  pld_chan_in_type  [NUM_CH-1:0] ci;
  pld_chan_out_type [NUM_CH-1:0] co;
  int                            n_errors;
  int                            total_checks;
  logic [7:0]                    d;
  logic [1:0]                    r;
  logic [7:0]                    prof [5];

  pld_phase_lock_detector i_dut (.core_clk(core_clk), .rst_n(rst_n), .axiReq(req),
    .axiResp(resp), .chanIn(ci), .chanOut(co));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic hang;
    check("timeout", 8'h01, 8'h00);
    summarize();
  endtask

  task automatic wr(input logic [13:0] idx, input logic [7:0] v);
    int k;
    @(posedge core_clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= {idx, 2'b00};
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h0, v};
    req.wstrb   <= 4'hf;
    req.bready  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge core_clk);
      if (resp.awready) req.awvalid <= 1'b0;
      if (resp.wready) req.wvalid <= 1'b0;
      if (resp.bvalid) break;
    end
    r = resp.bresp;
    req.bready <= 1'b0;
    if (k == 64) hang();
  endtask

  task automatic rd(input logic [13:0] idx);
    int k;
    @(posedge core_clk);
    req.arvalid <= 1'b1;
    req.araddr  <= {idx, 2'b00};
    req.rready  <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge core_clk);
      if (resp.arready) req.arvalid <= 1'b0;
      if (resp.rvalid) break;
    end
    d = resp.rdata[7:0];
    r = resp.rresp;
    req.rready <= 1'b0;
    if (k == 64) hang();
  endtask

  task automatic rc(input string nm, input logic [13:0] idx, input logic [7:0] e,
                    input logic [1:0] er);
    rd(idx);
    check(nm, d, e);
    check({nm, "_resp"}, {6'h0, r}, {6'h0, er});
  endtask

  // Back-to-back samples, then the qualifier drops on the following edge and stays low
  task automatic smp(input int c, input logic signed [24:0] e, input logic sl, input int n);
    repeat (n) begin
      @(posedge core_clk);
      ci[c].sampleValid  <= 1'b1;
      ci[c].phaseErr     <= e;
      ci[c].slewLimiting <= sl;
    end
    @(posedge core_clk);
    ci[c].sampleValid  <= 1'b0;
    ci[c].slewLimiting <= 1'b0;
  endtask

  task automatic pl(input int c, input logic e);
    #1 check("locked", {7'h0, co[c].phaseLocked}, {7'h0, e});
  endtask

  initial begin
    n_errors = 0;
    total_checks = 0;
    rst_n = 1'b0;
    req = '0;
    ci = '0;
    ci[1].frequencyWord = NCO_T;
    prof = '{8'h00, 8'h00, 8'h01, 8'hff, 8'hff};
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rc("tub_lo0", IDX_TUB_LO[0], 8'h00, RESP_OKAY);
    check("nco_ramp", {7'h0, co[1].ncoWord > 0 && co[1].ncoWord < NCO_T}, 8'h01);
    rc("tub_hi0", IDX_TUB_HI[0], 8'hf8, RESP_OKAY);
    rc("status0", IDX_LIVE_STAT[0], 8'h00, RESP_OKAY);
    rc("events0", IDX_EVENT_LAT[0], 8'h00, RESP_OKAY);
    rc("bw1", IDX_FILTER_BW[1], 8'h00, RESP_OKAY);
    wr(IDX_FILTER_BW[0], 8'hfa);
    check("wr_resp", {6'h0, r}, {6'h0, RESP_OKAY});
    rc("bw0", IDX_FILTER_BW[0], 8'h0a, RESP_OKAY);
    wr(14'h3fff, 8'h55);
    check("wr_unmapped", {6'h0, r}, {6'h0, RESP_SLVERR});
    rc("unmapped", 14'h3fff, 8'h00, RESP_SLVERR);
    rc("clr_read", IDX_EVENT_CLR[0], 8'h00, RESP_OKAY);
    $display("test reset and registers done");
    // Threshold 65536 ps exercises the top threshold byte
    foreach (prof[i]) wr(IDX_PROFILE[0] + 14'(i), prof[i]);
    smp(0, -25'sd65536, 1'b0, 12);
    pl(0, 1'b0);
    rc("tub_1012", IDX_TUB_LO[0], 8'hf4, RESP_OKAY);
    smp(0, -25'sd65536, 1'b0, 1);
    pl(0, 1'b1);
    rc("status_lock", IDX_LIVE_STAT[0], 8'h02, RESP_OKAY);
    rc("ev_lock", IDX_EVENT_LAT[0], 8'h01, RESP_OKAY);
    smp(0, 25'sd0, 1'b0, 4);
    rc("full_lo", IDX_TUB_LO[0], 8'hff, RESP_OKAY);
    rc("full_hi", IDX_TUB_HI[0], 8'h07, RESP_OKAY);
    $display("test fill and lock done");
    smp(0, 25'sd65537, 1'b0, 12);
    pl(0, 1'b1);
    rc("mid_hi", IDX_TUB_HI[0], 8'hfc, RESP_OKAY);
    smp(0, -25'sd65537, 1'b0, 1);
    pl(0, 1'b0);
    rc("ev_both", IDX_EVENT_LAT[0], 8'h03, RESP_OKAY);
    wr(IDX_EVENT_CLR[0], 8'h01);
    rc("ev_clr0", IDX_EVENT_LAT[0], 8'h02, RESP_OKAY);
    wr(IDX_EVENT_CLR[0], 8'h02);
    rc("ev_clr1", IDX_EVENT_LAT[0], 8'h00, RESP_OKAY);
    smp(0, 25'sd65537, 1'b0, 4);
    rc("empty_hi", IDX_TUB_HI[0], 8'hf8, RESP_OKAY);
    $display("test drain and events done");
    smp(0, 25'sd0, 1'b0, 1);
    smp(0, 25'sd0, 1'b1, 1);
    rc("slew_lo", IDX_TUB_LO[0], 8'h00, RESP_OKAY);
    wr(IDX_PROFILE[0] + PROF_DRAIN, 8'h00);
    smp(0, 25'sd0, 1'b0, 1);
    smp(0, 25'sd65537, 1'b0, 3);
    rc("zero_lo", IDX_TUB_LO[0], 8'hff, RESP_OKAY);
    rc("zero_hi", IDX_TUB_HI[0], 8'hf8, RESP_OKAY);
    $display("test slew and zero step done");
    smp(0, 25'sd0, 1'b0, 12);
    pl(0, 1'b1);
    @(posedge core_clk);
    ci[0].freerun <= 1'b1;
    ci[1].holdover <= 1'b1;
    smp(0, 25'sd0, 1'b0, 1);
    pl(0, 1'b0);
    rc("free_stat", IDX_LIVE_STAT[0], 8'h00, RESP_OKAY);
    rc("free_lo", IDX_TUB_LO[0], 8'hf2, RESP_OKAY);
    smp(1, 25'sd0, 1'b1, 1);
    rc("ch1_lo", IDX_TUB_LO[1], 8'h00, RESP_OKAY);
    rc("ch1_hi", IDX_TUB_HI[1], 8'hf8, RESP_OKAY);
    rc("ch1_ev", IDX_EVENT_LAT[1], 8'h00, RESP_OKAY);
    $display("test freerun and channel one done");
    // Channel zero targets word zero, so the correction alone shows on its output
    check("comp_off", co[0].ncoWord[7:0], 8'h00);
    @(posedge core_clk);
    ci[0].compActive <= 1'b1;
    ci[0].compCorr   <= 24'sh000005;
    repeat (2) @(posedge core_clk);
    #1 check("comp_word", co[0].ncoWord[7:0], 8'h05);
    $display("test compensation done");
    summarize();
  end
endmodule
